// ### hw/mmcc_pkg.sv
// Types of the memory controller config block
package mmcc_pkg;
  typedef enum logic [1:0] {
    MMCC_SZ_NONE0 = 2'b00,
    MMCC_SZ_1M = 2'b01,
    MMCC_SZ_4M = 2'b10,
    MMCC_SZ_ABSENT = 2'b11
  } mmcc_size_type;
  typedef enum logic {
    MMCC_ST_IDLE = 1'b0,
    MMCC_ST_ACK = 1'b1
  } mmcc_bus_st_type;
  typedef struct packed {
    logic valid;
    logic [1:0] rsv_a;
    logic [4:0] base;
    logic [20:0] rsv_b;
    mmcc_size_type size;
    logic wide;
  } mmcc_bank_type;
  typedef struct packed {
    logic fast_diag_mode;
    logic second_pass;
    logic chk_mode;
    logic io1_sel;
    logic soft_log;
    logic flush_cache;
    logic rsv_a;
    logic [7:0] diag_bits;
    logic [7:0] rsv_b;
    logic [1:0] tmo_scale;
    logic mem_err_dis;
    logic refr_sel;
    logic [2:0] force_par;
    logic refr_dis;
    logic refr_force;
  } mmcc_mode_type;
  typedef struct packed {
    logic [14:0] rsv;
    logic ignore_mode;
    logic err_dis;
    logic [8:0] seg;
    logic [2:0] mask;
    logic [2:0] op_mode;
  } mmcc_rbam_type;
  typedef struct packed {
    logic hit;
    logic [2:0] bank;
    logic wide;
    logic size_4m;
  } mmcc_sel_type;
  typedef struct packed {
    logic ecc_en;
    logic soft_log;
    logic fast_diag_mode;
    logic second_pass;
    logic chk_mode;
    logic [7:0] diag_bits;
    logic [2:0] force_par;
    logic flush_cache;
    logic io1_sel;
  } mmcc_ctrl_type;
  typedef struct packed {
    logic chk_en;
    logic err_en;
    logic [8:0] seg;
    logic [2:0] mask;
    logic [2:0] op_mode;
  } mmcc_recon_type;
endpackage

// ### hw/mmcc_regs.svh
// Register map, reset values and cycle counts of the memory controller config block
`ifndef MMCC_REGS_SVH
`define MMCC_REGS_SVH
// Byte addresses and decode masks
`define MMCC_ARR_BASE 32'h2101_0000
`define MMCC_ARR_MASK 32'hFFFF_8000
`define MMCC_ARR_IDX_HI 14
`define MMCC_ARR_IDX_LO 2
`define MMCC_BANK_BASE 32'h2101_8000
`define MMCC_BANK_MASK 32'hFFFF_FFE0
`define MMCC_BANK_IDX_HI 4
`define MMCC_MODE_ADDR 32'h2101_8048
`define MMCC_RBAM_ADDR 32'h2101_804C
`define MMCC_STAT_ADDR 32'h2101_8050
// Memory address bits compared with a bank base
`define MMCC_MEM_BASE_HI 28
`define MMCC_MEM_BASE_LO 24
`define MMCC_MEM_4M_LO 26
`define MMCC_BASE_4M_LO 2
// Reset values
`define MMCC_BANK_RST 32'h0000_0000
`define MMCC_MODE_RST 32'h0000_0000
`define MMCC_RBAM_RST 32'h0000_0000
`define MMCC_ARR_RST 24'h00_0000
// Writable bits and status field positions
`define MMCC_BANK_WMASK 32'h9F00_0007
`define MMCC_MODE_WMASK 32'hFDFE_01FF
`define MMCC_RBAM_WMASK 32'h0001_FFFF
`define MMCC_ARR_WMASK 32'h00FF_FFFF
`define MMCC_STAT_TMO_BIT 0
`define MMCC_STAT_CNT_LO 16
// Cycle counts and largest array depth
`define MMCC_REFR_CYC 328
`define MMCC_TMO_CYC 2600
`define MMCC_ARR_MAX 8192
`endif

// ### hw/mmcc_top.sv
// Main memory controller configuration, refresh timer and bank decode
`include "mmcc_regs.svh"

module mmcc_top #(
  parameter int RB_DEPTH = `MMCC_ARR_MAX,
  parameter int REFR_ALT_CYC = 656,
  parameter int TMO_CYC_1 = 1300,
  parameter int TMO_CYC_2 = 650,
  parameter int TMO_CYC_3 = 325
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [31:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_mem_req,
  input wire logic [31:0] i_mem_addr,
  output mmcc_pkg::mmcc_sel_type o_mem_sel,
  output logic o_mem_timeout,
  output logic o_refresh,
  output mmcc_pkg::mmcc_ctrl_type o_ctrl,
  output mmcc_pkg::mmcc_recon_type o_recon,
  input wire logic [12:0] i_rb_idx,
  output logic [23:0] o_rb_data
);

  localparam int CW = 16;
  localparam logic [CW-1:0] REFR_P0 = CW'(`MMCC_REFR_CYC);
  localparam logic [CW-1:0] REFR_P1 = CW'(REFR_ALT_CYC);
  localparam logic [CW-1:0] TMO_P0 = CW'(`MMCC_TMO_CYC);
  localparam logic [CW-1:0] TMO_P1 = CW'(TMO_CYC_1);
  localparam logic [CW-1:0] TMO_P2 = CW'(TMO_CYC_2);
  localparam logic [CW-1:0] TMO_P3 = CW'(TMO_CYC_3);

  // Refuse settings the counters or decode cannot serve
  if (RB_DEPTH < 1 || RB_DEPTH > `MMCC_ARR_MAX) begin : g_bad_depth
    $error("RB_DEPTH out of range");
  end
  if (REFR_ALT_CYC < 2 || REFR_ALT_CYC >= (1 << CW)) begin : g_bad_refr
    $error("REFR_ALT_CYC out of range");
  end
  if (TMO_CYC_1 < 1 || TMO_CYC_2 < 1 || TMO_CYC_3 < 1
      || TMO_CYC_1 >= (1 << CW) || TMO_CYC_2 >= (1 << CW)
      || TMO_CYC_3 >= (1 << CW)) begin : g_bad_tmo
    $error("timeout counts out of range");
  end

  typedef struct packed {
    mmcc_pkg::mmcc_bus_st_type st;
    logic [31:0] rdata;
    mmcc_pkg::mmcc_bank_type [7:0] bank;
    mmcc_pkg::mmcc_mode_type mode;
    mmcc_pkg::mmcc_rbam_type rbam;
    logic [RB_DEPTH-1:0][23:0] arr;
    logic [CW-1:0] refr_cnt;
    logic [CW-1:0] tmo_cnt;
    logic tmo_busy;
    logic tmo_flag;
    logic frc_prev;
    logic [15:0] refr_num;
    logic refresh;
    logic timeout;
    mmcc_pkg::mmcc_sel_type sel;
    logic [23:0] rb_data;
  } mmcc_state_type;

  mmcc_state_type s_q;
  mmcc_state_type s_d;

  // Byte-lane merge limited to writable bits
  function automatic logic [31:0] wmerge(
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [3:0] be,
    input logic [31:0] wm
  );
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    m = m & wm;
    return (old & ~m) | (wd & m);
  endfunction

  // Address decode of the register bus
  logic req;
  logic hit_arr;
  logic hit_bank;
  logic hit_mode;
  logic hit_rbam;
  logic hit_stat;
  logic [12:0] arr_idx;
  logic [2:0] bank_idx;
  assign req = i_avs_read | i_avs_write;
  assign arr_idx = i_avs_address[`MMCC_ARR_IDX_HI:`MMCC_ARR_IDX_LO];
  assign bank_idx = i_avs_address[`MMCC_BANK_IDX_HI:`MMCC_ARR_IDX_LO];
  assign hit_arr = ((i_avs_address & `MMCC_ARR_MASK) == `MMCC_ARR_BASE)
                   && (32'(arr_idx) < 32'(RB_DEPTH));
  assign hit_bank = (i_avs_address & `MMCC_BANK_MASK) == `MMCC_BANK_BASE;
  assign hit_mode = i_avs_address == `MMCC_MODE_ADDR;
  assign hit_rbam = i_avs_address == `MMCC_RBAM_ADDR;
  assign hit_stat = i_avs_address == `MMCC_STAT_ADDR;

  // Memory access decode against the bank table, lowest bank wins
  mmcc_pkg::mmcc_sel_type sel_c;
  always_comb
  begin
    sel_c = '0;
    for (int b = 7; b >= 0; b--) begin
      if (s_q.bank[b].valid) begin
        if (s_q.bank[b].size == mmcc_pkg::MMCC_SZ_1M
            && i_mem_addr[`MMCC_MEM_BASE_HI:`MMCC_MEM_BASE_LO] == s_q.bank[b].base) begin
          sel_c.hit = 1'b1;
          sel_c.bank = 3'(b);
          sel_c.wide = s_q.bank[b].wide;
          sel_c.size_4m = 1'b0;
        end else if (s_q.bank[b].size == mmcc_pkg::MMCC_SZ_4M
                     && i_mem_addr[`MMCC_MEM_BASE_HI:`MMCC_MEM_4M_LO]
                        == s_q.bank[b].base[4:`MMCC_BASE_4M_LO]) begin
          sel_c.hit = 1'b1;
          sel_c.bank = 3'(b);
          sel_c.wide = s_q.bank[b].wide;
          sel_c.size_4m = 1'b1;
        end
      end
    end
  end

  // Selected timeout and refresh periods
  logic [CW-1:0] tmo_lim;
  logic [CW-1:0] refr_per;
  always_comb
  begin
    case (s_q.mode.tmo_scale)
      2'b00: tmo_lim = TMO_P0;
      2'b01: tmo_lim = TMO_P1;
      2'b10: tmo_lim = TMO_P2;
      2'b11: tmo_lim = TMO_P3;
      default: tmo_lim = TMO_P0;
    endcase
    refr_per = s_q.mode.refr_sel ? REFR_P1 : REFR_P0;
  end

  // Read data of the addressed register
  logic [31:0] rd_c;
  always_comb
  begin
    rd_c = '0;
    if (hit_arr) begin
      rd_c = {8'h00, s_q.arr[arr_idx]};
    end else if (hit_bank) begin
      rd_c = s_q.bank[bank_idx];
    end else if (hit_mode) begin
      rd_c = s_q.mode;
    end else if (hit_rbam) begin
      rd_c = s_q.rbam;
    end else if (hit_stat) begin
      rd_c[`MMCC_STAT_TMO_BIT] = s_q.tmo_flag;
      rd_c[`MMCC_STAT_CNT_LO +: 16] = s_q.refr_num;
    end
  end

  // Next state of the whole block
  always_comb
  begin
    s_d = s_q;
    s_d.refresh = 1'b0;
    s_d.timeout = 1'b0;
    s_d.sel = sel_c;
    s_d.rb_data = (32'(i_rb_idx) < 32'(RB_DEPTH)) ? s_q.arr[i_rb_idx] : '0;

    // Bus slave: answer one cycle after the request
    case (s_q.st)
      mmcc_pkg::MMCC_ST_IDLE:
      begin
        if (req) begin
          s_d.st = mmcc_pkg::MMCC_ST_ACK;
          s_d.rdata = rd_c;
        end
      end
      mmcc_pkg::MMCC_ST_ACK:
      begin
        s_d.st = mmcc_pkg::MMCC_ST_IDLE;
        if (i_avs_write) begin
          if (hit_arr) begin
            s_d.arr[arr_idx] = 24'(wmerge({8'h00, s_q.arr[arr_idx]}, i_avs_writedata,
                                          i_avs_byteenable, `MMCC_ARR_WMASK));
          end else if (hit_bank) begin
            s_d.bank[bank_idx] = wmerge(s_q.bank[bank_idx], i_avs_writedata,
                                        i_avs_byteenable, `MMCC_BANK_WMASK);
          end else if (hit_mode) begin
            s_d.mode = wmerge(s_q.mode, i_avs_writedata,
                              i_avs_byteenable, `MMCC_MODE_WMASK);
          end else if (hit_rbam) begin
            s_d.rbam = wmerge(s_q.rbam, i_avs_writedata,
                              i_avs_byteenable, `MMCC_RBAM_WMASK);
          end else if (hit_stat && i_avs_byteenable[0]
                       && i_avs_writedata[`MMCC_STAT_TMO_BIT]) begin
            s_d.tmo_flag = 1'b0;
          end
        end
      end
      default: s_d.st = mmcc_pkg::MMCC_ST_IDLE;
    endcase

    // Refresh interval timer and forced refresh
    s_d.frc_prev = s_q.mode.refr_force;
    if (s_q.mode.refr_force && !s_q.frc_prev) begin
      s_d.refresh = 1'b1;
      s_d.refr_cnt = refr_per - 1'b1;
    end else if (s_q.refr_cnt == '0) begin
      s_d.refr_cnt = refr_per - 1'b1;
      s_d.refresh = !s_q.mode.refr_dis;
    end else begin
      s_d.refr_cnt = s_q.refr_cnt - 1'b1;
    end
    if (s_d.refresh) begin
      s_d.refr_num = s_q.refr_num + 1'b1;
    end

    // Unanswered memory access runs into the bus timeout
    if (i_mem_req) begin
      s_d.tmo_busy = !sel_c.hit;
      s_d.tmo_cnt = '0;
    end else if (s_q.tmo_busy) begin
      if (s_q.tmo_cnt == tmo_lim - 1'b1) begin
        s_d.tmo_busy = 1'b0;
        s_d.timeout = 1'b1;
      end else begin
        s_d.tmo_cnt = s_q.tmo_cnt + 1'b1;
      end
    end
    if (s_d.timeout) begin
      s_d.tmo_flag = 1'b1; // Set wins over a clear
    end
  end

  // State register
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst) begin
      s_q <= '0;
      s_q.st <= mmcc_pkg::MMCC_ST_IDLE;
      for (int b = 0; b < 8; b++) begin
        s_q.bank[b] <= `MMCC_BANK_RST;
      end
      s_q.mode <= `MMCC_MODE_RST;
      s_q.rbam <= `MMCC_RBAM_RST;
      for (int i = 0; i < RB_DEPTH; i++) begin
        s_q.arr[i] <= `MMCC_ARR_RST;
      end
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs
  assign o_avs_waitrequest = req && (s_q.st != mmcc_pkg::MMCC_ST_ACK);
  assign o_avs_readdata = s_q.rdata;
  assign o_mem_sel = s_q.sel;
  assign o_mem_timeout = s_q.timeout;
  assign o_refresh = s_q.refresh;
  assign o_rb_data = s_q.rb_data;

  // Control fields handed to the controller datapath
  always_comb
  begin
    o_ctrl.ecc_en = !s_q.mode.mem_err_dis;
    o_ctrl.soft_log = s_q.mode.soft_log;
    o_ctrl.fast_diag_mode = s_q.mode.fast_diag_mode;
    o_ctrl.second_pass = s_q.mode.second_pass;
    o_ctrl.chk_mode = s_q.mode.chk_mode;
    o_ctrl.diag_bits = s_q.mode.diag_bits;
    o_ctrl.force_par = s_q.mode.force_par;
    o_ctrl.flush_cache = s_q.mode.flush_cache;
    o_ctrl.io1_sel = s_q.mode.io1_sel;
    o_recon.chk_en = !s_q.rbam.ignore_mode;
    o_recon.err_en = !s_q.rbam.err_dis;
    o_recon.seg = s_q.rbam.seg;
    o_recon.mask = s_q.rbam.mask;
    o_recon.op_mode = s_q.rbam.op_mode;
  end

endmodule // mmcc_top

// ### verification/mmcc_bench.sv
// Self-checking bench for the memory controller config block
`include "mmcc_regs.svh"
module mmcc_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RBD = 16;
  localparam int REFR_ALT = 656;
  localparam int TMO_S3 = 325;
  localparam logic [31:0] ADDR_T[5] = '{32'h0512_3456, 32'h0D00_0000, 32'h0F80_0000,
    32'h0700_0000, 32'h0900_0000};
  localparam logic [5:0] SEL_T[5] = '{6'h22, 6'h25, 6'h25, 6'h00, 6'h00};
  logic i_clk = 1'b0, i_rst = 1'b1, i_avs_read = 1'b0, i_avs_write = 1'b0;
  logic [31:0] i_avs_address = 32'h0000_0000, i_avs_writedata = 32'h0000_0000;
  logic [3:0] i_avs_byteenable = 4'hF;
  logic [12:0] i_rb_idx = 13'h0000;
  logic [31:0] o_avs_readdata, mem_addr, d;
  logic o_avs_waitrequest, mem_req, o_mem_timeout, o_refresh;
  mmcc_pkg::mmcc_sel_type o_mem_sel;
  mmcc_pkg::mmcc_ctrl_type o_ctrl;
  mmcc_pkg::mmcc_recon_type o_recon;
  logic [23:0] o_rb_data;
  logic [63:0] exp_q[$];
  int n_errors = 0, num_checks = 0, seed = 14668, cyc = 0, n;
  always #5 i_clk = ~i_clk;
  mmcc_top #(.RB_DEPTH(RBD)) dut_u (.i_clk, .i_rst, .i_avs_address, .i_avs_read,
    .i_avs_write, .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest,
    .i_mem_req(mem_req), .i_mem_addr(mem_addr), .o_mem_sel, .o_mem_timeout, .o_refresh,
    .o_ctrl, .o_recon, .i_rb_idx, .o_rb_data);
  mmcc_mem_master u_mem (.i_clk, .o_req(mem_req), .o_addr(mem_addr));
  task automatic check(input string what, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Bus access; a read notes its expected word and compare mask
  task automatic acc(input bit wr, input logic [31:0] a, v, m = 32'hFFFF_FFFF);
    @(posedge i_clk);
    if (!wr) exp_q.push_back({m, v & m});
    i_avs_address <= a;
    i_avs_writedata <= v;
    i_avs_write <= wr;
    i_avs_read <= !wr;
    // Hold the request until an edge samples waitrequest low
    do @(posedge i_clk); while (o_avs_waitrequest);
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
  endtask
  // Cycles until a refresh (refr set) or timeout pulse, capped at 3000
  task automatic wait_hi(input bit refr, output int k);
    k = 0;
    do
    begin
      @(negedge i_clk);
      k++;
    end
    while (!(refr ? o_refresh : o_mem_timeout) && k < 3000);
  endtask
  // Read answers compared with the oldest note
  always @(negedge i_clk)
    if (i_avs_read && !o_avs_waitrequest)
    begin
      check("readdata", o_avs_readdata & exp_q[0][63:32], exp_q[0][31:0]);
      exp_q.pop_front();
    end
  // Hang guard
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      finish_test();
    end
  end
  initial
  begin
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    for (int b = 0; b < 8; b++) acc(0, `MMCC_BANK_BASE + 4 * b, 0);
    acc(0, `MMCC_MODE_ADDR, 0);
    acc(0, `MMCC_RBAM_ADDR, 0);
    acc(0, `MMCC_ARR_BASE + 4 * (RBD - 1), 0);
    $display("reset values done");
    // Random patterns, read back and seen on the outputs
    repeat (4)
    begin
      d = $random(seed);
      acc(1, `MMCC_MODE_ADDR, d);
      acc(0, `MMCC_MODE_ADDR, d & `MMCC_MODE_WMASK);
      check("ecc_en", o_ctrl.ecc_en, !d[6]);
      check("diag", {o_ctrl.diag_bits, o_ctrl.force_par}, {d[24:17], d[4:2]});
      check("soft_log", o_ctrl.soft_log, d[27]);
      check("diag_mode", o_ctrl[15:13], d[31:29]);
      acc(1, `MMCC_RBAM_ADDR, d);
      acc(0, `MMCC_RBAM_ADDR, d & `MMCC_RBAM_WMASK);
      check("recon", o_recon, {!d[16], !d[15], d[14:0]});
      acc(1, `MMCC_ARR_BASE + 4 * d[3:0], d);
      acc(0, `MMCC_ARR_BASE + 4 * d[3:0], d & `MMCC_ARR_WMASK);
      i_rb_idx <= {9'h000, d[3:0]};
      @(posedge i_clk);
      @(negedge i_clk);
      check("rb_data", o_rb_data, d[23:0]);
    end
    @(posedge i_clk);
    i_rb_idx <= 13'(RBD);
    acc(1, `MMCC_ARR_BASE + 4 * RBD, d);
    acc(0, `MMCC_ARR_BASE + 4 * RBD, 0);
    check("rb_range", o_rb_data, 0);
    acc(1, `MMCC_MODE_ADDR, 0);
    acc(1, `MMCC_RBAM_ADDR, 0);
    $display("register patterns done");
    // Banks: 1MB wide, 4MB, absent, not valid
    acc(1, `MMCC_BANK_BASE, 32'h8500_0003);
    acc(1, `MMCC_BANK_BASE + 4, 32'h8C00_0004);
    acc(1, `MMCC_BANK_BASE + 8, 32'h8700_0006);
    acc(1, `MMCC_BANK_BASE + 12, 32'h0900_0002);
    acc(0, `MMCC_BANK_BASE + 4, 32'h8C00_0004);
    foreach (ADDR_T[i])
    begin
      u_mem.access(ADDR_T[i]);
      @(negedge i_clk);
      check("mem_sel", SEL_T[i][5] ? o_mem_sel : o_mem_sel.hit, SEL_T[i]);
    end
    wait_hi(0, n);
    check("tmo_cycles", n, `MMCC_TMO_CYC);
    acc(0, `MMCC_STAT_ADDR, 1, 1);
    acc(1, `MMCC_STAT_ADDR, 1);
    acc(0, `MMCC_STAT_ADDR, 0, 1);
    $display("decode and timeout done");
    // Refresh period, suppression, forced refresh, alternate period
    wait_hi(1, n);
    wait_hi(1, n);
    check("refr_period", n, `MMCC_REFR_CYC);
    acc(1, `MMCC_MODE_ADDR, 2);
    wait_hi(1, n);
    check("refr_off", n, 3000);
    acc(1, `MMCC_MODE_ADDR, 1);
    wait_hi(1, n);
    check("refr_force", n, 2);
    wait_hi(1, n);
    check("refr_restart", n, `MMCC_REFR_CYC);
    acc(1, `MMCC_MODE_ADDR, 32'h0000_0020);
    wait_hi(1, n);
    wait_hi(1, n);
    check("refr_alt", n, REFR_ALT);
    $display("refresh done");
    // Shortest timeout scaler on an absent bank
    acc(1, `MMCC_MODE_ADDR, 32'h0000_0180);
    u_mem.access(32'h0700_0000);
    @(negedge i_clk);
    wait_hi(0, n);
    check("tmo_scale", n, TMO_S3);
    $display("timeout scaler done");
    finish_test();
  end
endmodule // mmcc_bench

// ### verification/mmcc_mem_master.sv
// Processor-side memory access source for the decode port
module mmcc_mem_master (
  input wire logic i_clk,
  output logic o_req,
  output logic [31:0] o_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    o_req = 1'b0;
    o_addr = 32'h0000_0000;
  end
  // One-cycle request; the address is then turned over, not left standing
  task automatic access(input logic [31:0] a);
    @(posedge i_clk);
    o_req <= 1'b1;
    o_addr <= a;
    @(posedge i_clk);
    o_req <= 1'b0;
    o_addr <= ~a;
  endtask
endmodule // mmcc_mem_master

// ### verification/mmcc_top_sva.sv
// Concurrent checks on the config block ports
module mmcc_top_sva #(
  parameter int RB_DEPTH = 16
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic o_avs_waitrequest,
  input wire logic i_mem_req,
  input wire logic o_mem_timeout,
  input wire logic o_refresh,
  input wire mmcc_pkg::mmcc_ctrl_type o_ctrl,
  input wire mmcc_pkg::mmcc_recon_type o_recon,
  input wire logic [12:0] i_rb_idx,
  input wire logic [23:0] o_rb_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] idle_q;
  // Cycles since the last memory request, saturating
  always_ff @(posedge i_clk or posedge i_rst)
    if (i_rst) idle_q <= 12'h000;
    else if (i_mem_req) idle_q <= 12'h000;
    else if (idle_q != 12'hFFF) idle_q <= idle_q + 12'h001;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence s_wait_once; o_avs_waitrequest ##1 !o_avs_waitrequest; endsequence
  sequence s_first_refr; !o_refresh ##1 o_refresh ##1 !o_refresh; endsequence
  property p_bus_wait; $rose(i_avs_read || i_avs_write) |-> s_wait_once; endproperty
  property p_rst_ctrl; $fell(i_rst) |-> o_ctrl.ecc_en && o_ctrl[16:2] == 15'h0000; endproperty
  property p_rst_recon; $fell(i_rst) |-> o_recon == 17'h1_8000; endproperty
  property p_refr_first; $fell(i_rst) |-> s_first_refr; endproperty
  property p_refr_gap; o_refresh |=> !o_refresh; endproperty
  property p_tmo;
    o_mem_timeout |-> idle_q inside {12'hA28, 12'h514, 12'h28A, 12'h145};
  endproperty
  property p_tmo_once; o_mem_timeout |=> !o_mem_timeout; endproperty
  property p_rb_range; i_rb_idx >= RB_DEPTH |=> o_rb_data == 24'h00_0000; endproperty
  a_bus_wait: assert property (p_bus_wait) else $error("wait not one cycle");
  a_rst_ctrl: assert property (p_rst_ctrl) else $error("ctrl reset value");
  a_rst_recon: assert property (p_rst_recon) else $error("recon reset value");
  a_refr_first: assert property (p_refr_first) else $error("first refresh");
  a_refr_gap: assert property (p_refr_gap) else $error("refresh pulse long");
  a_tmo: assert property (p_tmo) else $error("timeout count");
  a_tmo_once: assert property (p_tmo_once) else $error("timeout pulse long");
  a_rb_range: assert property (p_rb_range) else $error("array index range");
endmodule // mmcc_top_sva
bind mmcc_top mmcc_top_sva #(.RB_DEPTH(RB_DEPTH)) u_sva (.i_clk, .i_rst, .i_avs_read,
  .i_avs_write, .o_avs_waitrequest, .i_mem_req, .o_mem_timeout, .o_refresh, .o_ctrl,
  .o_recon, .i_rb_idx, .o_rb_data);
